// ---- design/plc_pkg.sv ----
// Purpose: shared constants and types of the lamp, crossover and pause bank
// Assumes: 16-bit registers in the low half of 32-bit AXI4-Lite words
// Notes: byte address of a register is four times its index
package plc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int IRQ_W = 3;

    // register indices and byte addresses
    localparam logic [7:0] IDX_RBR = 8'h17;
    localparam logic [7:0] IDX_LED = 8'h18;
    localparam logic [7:0] IDX_PHY = 8'h19;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h1D;
    localparam logic [7:0] ADDR_RBR = {IDX_RBR[5:0], 2'h0};
    localparam logic [7:0] ADDR_LED = {IDX_LED[5:0], 2'h0};
    localparam logic [7:0] ADDR_PHY = {IDX_PHY[5:0], 2'h0};
    localparam logic [7:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[5:0], 2'h0};
    localparam logic [7:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[5:0], 2'h0};

    // field positions
    localparam int RBR_UNF_BIT = 2;
    localparam int RBR_OVF_BIT = 3;
    localparam int LED_FIELD_W = 6;
    localparam int PHY_AUTO_CROSSOVER_ENABLE_BIT = 15;
    localparam int PHY_FORCE_BIT = 14;
    localparam int PHY_PAUSE_RX_BIT = 13;
    localparam int PHY_PAUSE_TX_BIT = 12;
    localparam int PHY_SELFTEST_FE_BIT = 11;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_UNF_BIT = 1;
    localparam int IRQ_PAUSE_BIT = 2;

    // reset values
    localparam logic [1:0] ELASTIC_RST = 2'h1;
    localparam logic [5:0] LED_RST = 6'h00;
    localparam logic FORCE_RST = 1'b0;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // slip allowance in bits for each elasticity code
    localparam logic [3:0] SLIP_BITS_00 = 4'hE;
    localparam logic [3:0] SLIP_BITS_01 = 4'h2;
    localparam logic [3:0] SLIP_BITS_10 = 4'h6;
    localparam logic [3:0] SLIP_BITS_11 = 4'hA;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic spd_ovr;
        logic lnk_ovr;
        logic act_ovr;
        logic spd_val;
        logic lnk_val;
        logic act_val;
    } plc_led_ctrl_type;

    typedef struct packed {
        logic speed;
        logic link;
        logic activity;
    } plc_led_status_type;

    typedef struct packed {
        logic local_asm_dir;
        logic local_pause;
        logic partner_asm_dir;
        logic partner_pause;
        logic full_duplex;
    } plc_pause_in_type;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'h0,
        WR_APPLY = 2'h1,
        WR_RESP = 2'h3
    } plc_wr_state_type;
endpackage

// ---- design/plc_led_drive.sv ----
// Purpose: one lamp output, normal indication or software forced value
// Assumes: inputs on aclk
// Notes: output is registered
`timescale 1ns/10ps
module plc_led_drive (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic override,
    input wire logic value,
    input wire logic normal,
    output logic lamp
);
    logic lamp_ff;

    // R5 R6 R7: override lamp select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lamp_ff <= 1'b0;
        end else begin
            lamp_ff <= override ? value : normal;
        end
    end

    assign lamp = lamp_ff;
endmodule

// ---- design/plc_regs.sv ----
// Purpose: lamp, crossover, elasticity and pause register bank on AXI4-Lite
// Assumes: datapath status inputs are on aclk; strap pin is asynchronous
// Notes: reset must be held long enough for the strap to settle
// Behaviour
// R1: elasticity code 00/01/10/11 selects 14/2/6/10 bits slip allowance
// R2: elasticity field resets to code 01, smallest tolerance
// R3: software halves packet lengths when both clocks are 100ppm off
// R4: lamp register bits 15:6 read zero, writes to them ignored
// R5: speed override set drives speed lamp from stored speed value
// R6: link override set drives link lamp from stored link value
// R7: activity override set drives activity lamp from stored value
// R8: lamp register reads stored bits, never the live lamp outputs
// R9: crossover auto enable bit 15, reset value from strap pin
// R10: software enables auto crossover only with auto-negotiation on
// R11: force bit 14 crosses the line pairs
// R12: bit 13 reports resolved receive pause, full duplex only
// R13: bit 12 reports resolved transmit pause, full duplex only
// R14: writing one to self-test error bit injects one error, self clears
// R15: receive fifo overflow and underflow bits read one when detected
// R16: writes to pause bits ignored, reads give resolved values
`timescale 1ns/10ps
module plc_regs
    import plc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [STRB_W-1:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic mdix_strap_pin,
    input wire plc_led_status_type led_normal,
    input wire plc_pause_in_type pause_in,
    input wire logic rx_fifo_overflow_det,
    input wire logic rx_fifo_underflow_det,
    output logic speed_lamp_out,
    output logic link_lamp_out,
    output logic activity_lamp_out,
    output logic [1:0] rx_elastic_tolerance,
    output logic [3:0] rx_slip_bits,
    output logic auto_crossover_enable,
    output logic force_crossover,
    output logic pause_rx_enable,
    output logic pause_tx_enable,
    output logic selftest_force_error,
    output logic irq
);
    plc_wr_state_type wr_state_ff;
    plc_wr_state_type nxt_wr_state;
    logic aw_held_ff;
    logic w_held_ff;
    logic nxt_aw_held;
    logic nxt_w_held;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [STRB_W-1:0] wstrb_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_apply;
    logic wr_err;
    logic wr_lo;
    logic wr_hi;
    logic [DATA_W-1:0] rd_word;
    logic rd_err;
    logic [1:0] elastic_ff;
    logic [3:0] slip_bits_ff;
    logic [3:0] nxt_slip_bits;
    plc_led_ctrl_type led_ctrl_ff;
    logic auto_crossover_enable_ff;
    logic force_ff;
    logic fe_pulse_ff;
    logic strap_s1_ff;
    logic strap_s2_ff;
    logic strap_s3_ff;
    logic strap_flt_ff;
    logic strap_taken_ff;
    logic pause_rx_ff;
    logic pause_tx_ff;
    logic nxt_pause_rx;
    logic nxt_pause_tx;
    logic rx_ovf_ff;
    logic rx_unf_ff;
    logic [IRQ_W-1:0] irq_status_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic [IRQ_W-1:0] nxt_irq_status;
    logic [IRQ_W-1:0] nxt_irq_mask;
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_clr;
    logic irq_ff;

    assign aw_take = s_axi_awvalid & awready_ff;
    assign w_take = s_axi_wvalid & wready_ff;
    assign ar_take = s_axi_arvalid & arready_ff;
    assign wr_apply = (wr_state_ff == WR_APPLY);
    assign wr_lo = wr_apply & wstrb_ff[0];
    assign wr_hi = wr_apply & wstrb_ff[1];

    // write channel sequencing
    always_comb begin
        nxt_wr_state = wr_state_ff;
        case (wr_state_ff)
            WR_COLLECT: begin
                if (aw_held_ff && w_held_ff) begin
                    nxt_wr_state = WR_APPLY;
                end
            end
            WR_APPLY: begin
                nxt_wr_state = WR_RESP;
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    nxt_wr_state = WR_COLLECT;
                end
            end
            default: begin
                nxt_wr_state = WR_COLLECT;
            end
        endcase
        nxt_aw_held = wr_apply ? 1'b0 : (aw_held_ff | aw_take);
        nxt_w_held = wr_apply ? 1'b0 : (w_held_ff | w_take);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= WR_COLLECT;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            wr_state_ff <= nxt_wr_state;
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awready_ff <= (nxt_wr_state == WR_COLLECT) & ~nxt_aw_held;
            wready_ff <= (nxt_wr_state == WR_COLLECT) & ~nxt_w_held;
            bvalid_ff <= (nxt_wr_state == WR_RESP);
            if (wr_apply) begin
                bresp_ff <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    // captured write payload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
        end
    end

    always_comb begin
        wr_err = 1'b0;
        if (awaddr_ff == ADDR_RBR) begin
            wr_err = 1'b0;
        end else if (awaddr_ff == ADDR_LED) begin
            wr_err = 1'b0;
        end else if (awaddr_ff == ADDR_PHY) begin
            wr_err = 1'b0;
        end else if (awaddr_ff == ADDR_IRQ_STATUS) begin
            wr_err = 1'b0;
        end else if (awaddr_ff == ADDR_IRQ_MASK) begin
            wr_err = 1'b0;
        end else begin
            wr_err = 1'b1;
        end
    end

    // read data, R4 R8 R12 R13 R15 R16: stored and live bits
    always_comb begin
        rd_word = '0;
        rd_err = 1'b0;
        if (s_axi_araddr == ADDR_RBR) begin
            rd_word[1:0] = elastic_ff;
            rd_word[RBR_UNF_BIT] = rx_unf_ff;
            rd_word[RBR_OVF_BIT] = rx_ovf_ff;
        end else if (s_axi_araddr == ADDR_LED) begin
            rd_word[LED_FIELD_W-1:0] = led_ctrl_ff;
        end else if (s_axi_araddr == ADDR_PHY) begin
            rd_word[PHY_AUTO_CROSSOVER_ENABLE_BIT] = auto_crossover_enable_ff;
            rd_word[PHY_FORCE_BIT] = force_ff;
            rd_word[PHY_PAUSE_RX_BIT] = pause_rx_ff;
            rd_word[PHY_PAUSE_TX_BIT] = pause_tx_ff;
        end else if (s_axi_araddr == ADDR_IRQ_STATUS) begin
            rd_word[IRQ_W-1:0] = irq_status_ff;
        end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
            rd_word[IRQ_W-1:0] = irq_mask_ff;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else begin
            if (ar_take) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_word;
                rresp_ff <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end else if (!rvalid_ff) begin
                arready_ff <= 1'b1;
            end
        end
    end

    // R1: slip allowance lookup
    always_comb begin
        case (elastic_ff)
            2'h0: nxt_slip_bits = SLIP_BITS_00;
            2'h1: nxt_slip_bits = SLIP_BITS_01;
            2'h2: nxt_slip_bits = SLIP_BITS_10;
            default: nxt_slip_bits = SLIP_BITS_11;
        endcase
    end

    // R2: elasticity reset code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            elastic_ff <= ELASTIC_RST;
            slip_bits_ff <= SLIP_BITS_01;
        end else begin
            if (wr_lo && awaddr_ff == ADDR_RBR) begin
                elastic_ff <= wdata_ff[1:0];
            end
            slip_bits_ff <= nxt_slip_bits;
        end
    end

    // R4: only low six bits stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_ctrl_ff <= LED_RST;
        end else if (wr_lo && awaddr_ff == ADDR_LED) begin
            led_ctrl_ff <= wdata_ff[LED_FIELD_W-1:0];
        end
    end

    // strap synchroniser, filtered when stages two and three agree
    always_ff @(posedge aclk) begin
        strap_s1_ff <= mdix_strap_pin;
        strap_s2_ff <= strap_s1_ff;
        strap_s3_ff <= strap_s2_ff;
        if (strap_s2_ff == strap_s3_ff) begin
            strap_flt_ff <= strap_s3_ff;
        end
    end

    // R9: auto crossover, strap loaded after release
    // R11: forced pair crossing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_taken_ff <= 1'b0;
            auto_crossover_enable_ff <= 1'b0;
            force_ff <= FORCE_RST;
        end else begin
            strap_taken_ff <= 1'b1;
            if (!strap_taken_ff) begin
                auto_crossover_enable_ff <= strap_flt_ff;
            end else if (wr_hi && awaddr_ff == ADDR_PHY) begin
                auto_crossover_enable_ff <= wdata_ff[PHY_AUTO_CROSSOVER_ENABLE_BIT];
            end
            if (wr_hi && awaddr_ff == ADDR_PHY) begin
                force_ff <= wdata_ff[PHY_FORCE_BIT];
            end
        end
    end

    // R14: single error pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fe_pulse_ff <= 1'b0;
        end else begin
            fe_pulse_ff <= wr_hi & (awaddr_ff == ADDR_PHY) &
                wdata_ff[PHY_SELFTEST_FE_BIT];
        end
    end

    // R12 R13: pause resolution
    always_comb begin
        nxt_pause_tx = pause_in.full_duplex & pause_in.partner_pause &
            (pause_in.local_pause |
            (pause_in.local_asm_dir & pause_in.partner_asm_dir));
        nxt_pause_rx = pause_in.full_duplex & pause_in.local_pause &
            (pause_in.partner_pause |
            (pause_in.local_asm_dir & pause_in.partner_asm_dir));
    end

    // R12 R13 R15: pause and fifo status capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_rx_ff <= 1'b0;
            pause_tx_ff <= 1'b0;
            rx_ovf_ff <= 1'b0;
            rx_unf_ff <= 1'b0;
        end else begin
            pause_rx_ff <= nxt_pause_rx;
            pause_tx_ff <= nxt_pause_tx;
            rx_ovf_ff <= rx_fifo_overflow_det;
            rx_unf_ff <= rx_fifo_underflow_det;
        end
    end

    // interrupt status, set wins over write-one clear
    always_comb begin
        irq_evt = '0;
        irq_evt[IRQ_OVF_BIT] = rx_fifo_overflow_det & ~rx_ovf_ff;
        irq_evt[IRQ_UNF_BIT] = rx_fifo_underflow_det & ~rx_unf_ff;
        irq_evt[IRQ_PAUSE_BIT] = (nxt_pause_rx ^ pause_rx_ff) |
            (nxt_pause_tx ^ pause_tx_ff);
        irq_clr = '0;
        nxt_irq_mask = irq_mask_ff;
        if (wr_lo && awaddr_ff == ADDR_IRQ_STATUS) begin
            irq_clr = wdata_ff[IRQ_W-1:0];
        end
        if (wr_lo && awaddr_ff == ADDR_IRQ_MASK) begin
            nxt_irq_mask = wdata_ff[IRQ_W-1:0];
        end
        nxt_irq_status = (irq_status_ff & ~irq_clr) | irq_evt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_ff <= '0;
            irq_mask_ff <= IRQ_MASK_RST;
            irq_ff <= 1'b0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff <= |(nxt_irq_status & nxt_irq_mask);
        end
    end

    // R5: speed lamp
    plc_led_drive u_speed_lamp (
        .aclk(aclk),
        .aresetn(aresetn),
        .override(led_ctrl_ff.spd_ovr),
        .value(led_ctrl_ff.spd_val),
        .normal(led_normal.speed),
        .lamp(speed_lamp_out)
    );

    // R6: link lamp
    plc_led_drive u_link_lamp (
        .aclk(aclk),
        .aresetn(aresetn),
        .override(led_ctrl_ff.lnk_ovr),
        .value(led_ctrl_ff.lnk_val),
        .normal(led_normal.link),
        .lamp(link_lamp_out)
    );

    // R7: activity lamp
    plc_led_drive u_activity_lamp (
        .aclk(aclk),
        .aresetn(aresetn),
        .override(led_ctrl_ff.act_ovr),
        .value(led_ctrl_ff.act_val),
        .normal(led_normal.activity),
        .lamp(activity_lamp_out)
    );

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign rx_elastic_tolerance = elastic_ff;
    assign rx_slip_bits = slip_bits_ff;
    assign auto_crossover_enable = auto_crossover_enable_ff;
    assign force_crossover = force_ff;
    assign pause_rx_enable = pause_rx_ff;
    assign pause_tx_enable = pause_tx_ff;
    assign selftest_force_error = fe_pulse_ff;
    assign irq = irq_ff;

    property p_elastic_reset;
        @(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> rx_elastic_tolerance == 2'h1 &&
            rx_slip_bits == 4'h2;
    endproperty
    a_elastic_reset: assert property (p_elastic_reset) // R2
        else $error("elasticity reset code wrong");

    property p_slip_map;
        @(posedge aclk) disable iff (!aresetn)
        $stable(rx_elastic_tolerance) |-> rx_slip_bits ==
            (rx_elastic_tolerance == 2'h0 ? 4'hE :
            rx_elastic_tolerance == 2'h1 ? 4'h2 :
            rx_elastic_tolerance == 2'h2 ? 4'h6 : 4'hA);
    endproperty
    a_slip_map: assert property (p_slip_map) // R1
        else $error("slip allowance mismatch");

    property p_led_upper_zero;
        @(posedge aclk) disable iff (!aresetn)
        ar_take && s_axi_araddr == ADDR_LED |=>
            s_axi_rdata[31:6] == 26'h0 &&
            s_axi_rdata[5:0] == $past(led_ctrl_ff);
    endproperty
    a_led_upper_zero: assert property (p_led_upper_zero) // R4 R8
        else $error("lamp register read wrong");

    property p_speed_force;
        @(posedge aclk) disable iff (!aresetn)
        led_ctrl_ff.spd_ovr |=> speed_lamp_out == $past(led_ctrl_ff.spd_val);
    endproperty
    a_speed_force: assert property (p_speed_force) // R5
        else $error("speed lamp not forced");

    property p_link_follow;
        @(posedge aclk) disable iff (!aresetn)
        !led_ctrl_ff.lnk_ovr |=> link_lamp_out == $past(led_normal.link);
    endproperty
    a_link_follow: assert property (p_link_follow) // R6
        else $error("link lamp not following");

    property p_act_force;
        @(posedge aclk) disable iff (!aresetn)
        led_ctrl_ff.act_ovr |=>
            activity_lamp_out == $past(led_ctrl_ff.act_val);
    endproperty
    a_act_force: assert property (p_act_force) // R7
        else $error("activity lamp not forced");

    property p_phy_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_hi && awaddr_ff == ADDR_PHY && strap_taken_ff |=>
            auto_crossover_enable == $past(wdata_ff[15]) &&
            force_crossover == $past(wdata_ff[14]);
    endproperty
    a_phy_write: assert property (p_phy_write) // R9 R11
        else $error("crossover bits not written");

    property p_half_duplex;
        @(posedge aclk) disable iff (!aresetn)
        !pause_in.full_duplex |=> !pause_rx_enable && !pause_tx_enable;
    endproperty
    a_half_duplex: assert property (p_half_duplex) // R12 R13
        else $error("pause on in half duplex");

    property p_sym_pause;
        @(posedge aclk) disable iff (!aresetn)
        pause_in.full_duplex && pause_in.local_pause &&
            pause_in.partner_pause |=> pause_rx_enable && pause_tx_enable;
    endproperty
    a_sym_pause: assert property (p_sym_pause) // R12 R13
        else $error("symmetric pause not resolved");

    property p_fe_pulse;
        @(posedge aclk) disable iff (!aresetn)
        wr_hi && awaddr_ff == ADDR_PHY && wdata_ff[11] |=>
            selftest_force_error ##1 !selftest_force_error;
    endproperty
    a_fe_pulse: assert property (p_fe_pulse) // R14
        else $error("self-test error not a single pulse");

    property p_ovf_status;
        @(posedge aclk) disable iff (!aresetn)
        rx_fifo_overflow_det |=> rx_ovf_ff ##0 irq_status_ff[0] ||
            $past(rx_ovf_ff);
    endproperty
    a_ovf_status: assert property (p_ovf_status) // R15
        else $error("overflow not reported");

    property p_bresp_bound;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aw_held_ff & w_held_ff) |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_bresp_bound: assert property (p_bresp_bound)
        else $error("write response late");

    c_led_force: cover property (@(posedge aclk) disable iff (!aresetn)
        led_ctrl_ff.spd_ovr ##1 speed_lamp_out);
    c_fe_write: cover property (@(posedge aclk) disable iff (!aresetn)
        selftest_force_error);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(irq));
    c_pause_rx_only: cover property (@(posedge aclk) disable iff (!aresetn)
        pause_rx_enable && !pause_tx_enable);
endmodule

// ---- tb/phy_led_mdix_control_regs_tb.sv ----
// Purpose: self-checking bench of the lamp, crossover and pause bank
// Assumes: strap pin high until a second reset, lanes strobed unless noted
// Notes: reads are checked by a monitor against a queue of notes
`timescale 1ns/10ps
module phy_led_mdix_control_regs_tb
    import plc_pkg::*;
;
    localparam logic [15:0] SLIPS = 16'hA62E;
    logic aclk, aresetn, awv, wv, bre, arv, rre, awr, wr_r, bv, arr, rv;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, d;
    logic [1:0] brsp, rrsp, tol;
    logic ovf, unf, spd, lnk, act, xen, xf, prx, ptx, fe, irq, strap;
    logic [3:0] slip, ws;
    logic [1:0] bq[$];
    logic [33:0] ex;
    plc_led_status_type nrm;
    plc_pause_in_type pin;
    logic [33:0] exp_q[$];
    int bad_count = 0, n_checks = 0, cyc = 0, fe_cnt = 0, seed, i;
    plc_regs plc_regs_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_bresp(brsp), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .mdix_strap_pin(strap),
        .led_normal(nrm), .pause_in(pin), .rx_fifo_overflow_det(ovf),
        .rx_fifo_underflow_det(unf), .speed_lamp_out(spd),
        .link_lamp_out(lnk), .activity_lamp_out(act),
        .rx_elastic_tolerance(tol), .rx_slip_bits(slip),
        .auto_crossover_enable(xen), .force_crossover(xf),
        .pause_rx_enable(prx), .pause_tx_enable(ptx),
        .selftest_force_error(fe), .irq(irq));
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task settle;
        @(posedge aclk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        bq.push_back((a == ADDR_RBR || a == ADDR_LED || a == ADDR_PHY ||
            a == ADDR_IRQ_STATUS || a == ADDR_IRQ_MASK) ?
            RESP_OKAY : RESP_SLVERR);
        @(posedge aclk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= v;
        bre <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr_r === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        bre <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        exp_q.push_back({r, e});
        @(posedge aclk);
        arv <= 1'b1;
        ara <= a;
        rre <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        rre <= 1'b0;
    endtask
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // read monitor takes the oldest note
    always @(posedge aclk) begin
        if (rv === 1'b1 && rre === 1'b1) begin
            ex = exp_q.pop_front();
            chk("rdata", ex[31:0], rdat);
            chk("rresp", {30'h0, ex[33:32]}, {30'h0, rrsp});
        end
        if (bv === 1'b1 && bre === 1'b1)
            chk("bresp", {30'h0, bq.pop_front()}, {30'h0, brsp});
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (fe === 1'b1) fe_cnt <= fe_cnt + 1;
        if (cyc == 5000) begin
            bad_count++;
            give_verdict;
        end
    end
    initial begin
        seed = 71;
        {aresetn, awv, wv, bre, arv, rre, ovf, unf} = 8'h00;
        {awa, ara, wd, nrm, pin} = 56'h0;
        ws = 4'hF;
        strap = 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        settle;
        chk("xen", 32'h1, xen);
        rd(ADDR_RBR, 32'h1, RESP_OKAY);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            wr(ADDR_RBR, i);
            settle;
            chk("tol", i, tol);
            chk("slip", SLIPS[i*4 +: 4], slip);
            rd(ADDR_RBR, i, RESP_OKAY);
        end
        $display("test elasticity done");
        for (i = 0; i < 6; i++) begin
            d = $random(seed);
            nrm <= d[10:8];
            wr(ADDR_LED, d);
            settle;
            chk("spd", d[5] ? d[2] : nrm.speed, spd);
            chk("lnk", d[4] ? d[1] : nrm.link, lnk);
            chk("act", d[3] ? d[0] : nrm.activity, act);
            rd(ADDR_LED, {26'h0, d[5:0]}, RESP_OKAY);
        end
        ws <= 4'h0;
        wr(ADDR_LED, 32'h3F);
        ws <= 4'hF;
        rd(ADDR_LED, {26'h0, d[5:0]}, RESP_OKAY);
        $display("test lamps done");
        pin <= 5'h1F;
        wr(ADDR_PHY, 32'h7800);
        settle;
        chk("xf", 32'h1, xf);
        chk("xen", 32'h0, xen);
        chk("fe", 32'h1, fe_cnt);
        chk("pause", 32'h3, {prx, ptx});
        rd(ADDR_PHY, 32'h7000, RESP_OKAY);
        pin <= 5'h1E;
        wr(ADDR_PHY, 32'h8000);
        settle;
        chk("fe", 32'h1, fe_cnt);
        wr(8'hFC, 32'hFFFF);
        rd(ADDR_PHY, 32'h8000, RESP_OKAY);
        rd(8'hFC, 32'h0, RESP_SLVERR);
        $display("test control done");
        wr(ADDR_IRQ_STATUS, 32'h7);
        wr(ADDR_IRQ_MASK, 32'h7);
        settle;
        chk("irq", 32'h0, irq);
        @(posedge aclk);
        ovf <= 1'b1;
        unf <= 1'b1;
        settle;
        settle;
        chk("irq", 32'h1, irq);
        rd(ADDR_RBR, 32'hF, RESP_OKAY);
        wr(ADDR_IRQ_MASK, 32'h0);
        settle;
        chk("irq", 32'h0, irq);
        wr(ADDR_IRQ_MASK, 32'h7);
        wr(ADDR_IRQ_STATUS, 32'h7);
        settle;
        chk("irq", 32'h0, irq);
        $display("test interrupt done");
        @(posedge aclk);
        {aresetn, strap, ovf, unf, nrm} <= 7'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        settle;
        chk("xen", 32'h0, xen);
        chk("tol", 32'h1, tol);
        $display("test second reset done");
        give_verdict;
    end
endmodule
